/* logic/bus_spacing_pkg.sv */
// Purpose: shared constants and types of the bus cycle spacing control
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   control fields repeat per area at a fixed stride
package bus_spacing_pkg;
	localparam logic [3:0]  ADDR_CTRL     = 4'h0;
	localparam logic [3:0]  ADDR_STAT     = 4'h4;
	localparam logic [15:0] CTRL_RESET    = 16'hFFFF;
	localparam int          IDLE_LSB      = 8;
	localparam int          IDLE_W        = 2;
	localparam int          GAP_LSB       = 4;
	localparam int          EXT_LSB       = 0;
	localparam int          STAT_BUSY     = 0;
	localparam int          STAT_AREA_LSB = 1;
	localparam int          STAT_WRITE    = 3;
	localparam int          STAT_PREV     = 4;
	localparam int          AREAS         = 4;
	localparam logic [1:0]  STROBE_CNT    = 2'h1;

	typedef enum logic [2:0]
	{
		S_IDLE,
		S_GAP,
		S_LEAD,
		S_STROBE,
		S_TRAIL
	} state_e;

	typedef struct packed
	{
		logic [1:0] area;
		logic       write;
	} access_s;
endpackage

/* logic/bus_cycle_spacing_control.sv */
// Purpose: idle spacing and select stretch for four select areas
// Assumes: requester on i_clk holds i_req_valid and i_req until o_ack
// Notes:   strobe phase is two cycles; ack comes in the first gap, lead or strobe cycle
// Function
// - area 2 idle field, low bit 12, gives 0..3 idle cycles, resets to 3.
// - area 1 idle field bits 11:10 encodes 0..3 idle cycles, resets to 3.
// - area 0 idle field bits 9:8 encodes 0..3 idle cycles, resets to 3.
// - same-area gap bit set: select deasserted once between same-area accesses.
// - write after read inserts the larger of turnaround and same-area idles.
// - same-area gap bits 7,6,5,4 belong to areas 3,2,1,0.
// - same-area gap bit clear gives no idle, set gives one; resets set.
// - with stretch on, strobes stay inside the select assert period.
// - stretch adds one select-only cycle before and after each bus cycle.
// - stretch bit clear disables, set enables; resets set.
// - turnaround idle count comes from the preceding access's area.
// - control register resets to all ones.
// - turnaround idles after read to another area, or read then write same area.
//
// The Avalon-MM register port and the register addresses were left to the implementer.
module bus_cycle_spacing_control
(
	input  wire logic                      i_clk,
	input  wire logic                      i_arst_n,
	input  wire logic [3:0]                i_address,
	input  wire logic                      i_read,
	input  wire logic                      i_write,
	input  wire logic [31:0]               i_writedata,
	input  wire logic [3:0]                i_byteenable,
	output      logic [31:0]               o_readdata,
	output      logic                      o_waitrequest,
	input  wire logic                      i_req_valid,
	input  wire bus_spacing_pkg::access_s  i_req,
	output      logic                      o_ack,
	output      logic [3:0]                o_area_select_n,
	output      logic                      o_read_strobe_n,
	output      logic                      o_write_strobe_n
);
	logic                      rst_meta;
	logic                      rst_n;
	logic [15:0]               bus_spacing_control;
	logic [15:0]               next_ctrl;
	logic                      next_wait;
	logic [31:0]               next_rdata;
	bus_spacing_pkg::state_e   state;
	bus_spacing_pkg::state_e   next_state;
	logic [1:0]                cnt;
	logic [1:0]                next_cnt;
	logic [1:0]                since;
	logic [1:0]                next_since;
	bus_spacing_pkg::access_s  cur;
	bus_spacing_pkg::access_s  next_cur;
	bus_spacing_pkg::access_s  prev;
	bus_spacing_pkg::access_s  next_prev;
	logic                      prev_valid;
	logic                      next_prev_valid;
	logic                      cur_ext;
	logic                      next_cur_ext;
	logic                      next_ack;
	logic [3:0]                next_sel_n;
	logic                      next_rd_n;
	logic                      next_wr_n;
	logic                      at_end;
	logic                      take;
	logic [1:0]                need;
	logic [1:0]                since_eff;
	logic [1:0]                rem;

	// idle field of one area
	function automatic logic [1:0] idle_of(input logic [15:0] c, input logic [1:0] a);
		idle_of = c[bus_spacing_pkg::IDLE_LSB + bus_spacing_pkg::IDLE_W * a +: 2];
	endfunction

	// idle cycles owed between previous access and a request
	function automatic logic [1:0] gap_need
	(
		input logic [15:0]               c,
		input bus_spacing_pkg::access_s  p,
		input bus_spacing_pkg::access_s  r
	);
		logic [1:0] iw;
		logic [1:0] cw;
		iw = idle_of(c, p.area);
		cw = {1'b0, c[bus_spacing_pkg::GAP_LSB + p.area]};
		if (p.area != r.area)
		begin
			gap_need = p.write ? 2'h0 : iw;
		end
		else if (!p.write && r.write)
		begin
			gap_need = (iw > cw) ? iw : cw;
		end
		else
		begin
			gap_need = cw;
		end
	endfunction

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// register slave: one wait cycle, then answer
	always_comb
	begin
		next_ctrl  = bus_spacing_control;
		next_wait  = 1'b1;
		next_rdata = o_readdata;
		if ((i_read || i_write) && o_waitrequest)
		begin
			next_wait  = 1'b0;
			next_rdata = 32'h0;
			if (i_address == bus_spacing_pkg::ADDR_CTRL)
			begin
				next_rdata[15:0] = bus_spacing_control;
			end
			else if (i_address == bus_spacing_pkg::ADDR_STAT)
			begin
				next_rdata[bus_spacing_pkg::STAT_BUSY] = (state != bus_spacing_pkg::S_IDLE);
				next_rdata[bus_spacing_pkg::STAT_AREA_LSB +: 2] = prev.area;
				next_rdata[bus_spacing_pkg::STAT_WRITE] = prev.write;
				next_rdata[bus_spacing_pkg::STAT_PREV] = prev_valid;
			end
		end
		if (i_write && !o_waitrequest && i_address == bus_spacing_pkg::ADDR_CTRL)
		begin
			if (i_byteenable[0])
			begin
				next_ctrl[7:0] = i_writedata[7:0];
			end
			if (i_byteenable[1])
			begin
				next_ctrl[15:8] = i_writedata[15:8];
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_spacing_control <= bus_spacing_pkg::CTRL_RESET;
			o_waitrequest       <= 1'b1;
			o_readdata          <= 32'h0;
		end
		else
		begin
			bus_spacing_control <= next_ctrl;
			o_waitrequest       <= next_wait;
			o_readdata          <= next_rdata;
		end
	end

	// cycle sequencing
	always_comb
	begin
		at_end = (state == bus_spacing_pkg::S_STROBE && cnt == 2'h0 && !cur_ext)
			|| state == bus_spacing_pkg::S_TRAIL;
		take = i_req_valid && !o_ack && (state == bus_spacing_pkg::S_IDLE || at_end);
		since_eff = at_end ? 2'h0 : since;
		need = prev_valid ? gap_need(bus_spacing_control, prev, i_req) : 2'h0;
		rem = at_end ? gap_need(bus_spacing_control, cur, i_req) : (need > since_eff) ? need - since_eff : 2'h0;
		next_state      = state;
		next_cnt        = cnt;
		next_since      = since;
		next_cur        = cur;
		next_cur_ext    = cur_ext;
		next_prev       = prev;
		next_prev_valid = prev_valid;
		next_ack        = 1'b0;
		if (at_end)
		begin
			next_prev       = cur;
			next_prev_valid = 1'b1;
			next_state      = bus_spacing_pkg::S_IDLE;
			next_since      = 2'h1;
		end
		case (state)
			bus_spacing_pkg::S_IDLE:
			begin
				if (since != 2'h3)
				begin
					next_since = since + 2'h1;
				end
			end
			bus_spacing_pkg::S_GAP:
			begin
				if (cnt != 2'h0)
				begin
					next_cnt = cnt - 2'h1;
				end
				else if (cur_ext)
				begin
					next_state = bus_spacing_pkg::S_LEAD;
				end
				else
				begin
					next_state = bus_spacing_pkg::S_STROBE;
					next_cnt   = bus_spacing_pkg::STROBE_CNT;
				end
			end
			bus_spacing_pkg::S_LEAD:
			begin
				next_state = bus_spacing_pkg::S_STROBE;
				next_cnt   = bus_spacing_pkg::STROBE_CNT;
			end
			bus_spacing_pkg::S_STROBE:
			begin
				if (cnt != 2'h0)
				begin
					next_cnt = cnt - 2'h1;
				end
				else if (cur_ext)
				begin
					next_state = bus_spacing_pkg::S_TRAIL;
				end
			end
			bus_spacing_pkg::S_TRAIL:
			begin
				next_state = bus_spacing_pkg::S_IDLE;
			end
			default:
			begin
				next_state = bus_spacing_pkg::S_IDLE;
			end
		endcase
		if (take)
		begin
			next_ack     = 1'b1;
			next_cur     = i_req;
			next_cur_ext = bus_spacing_control[bus_spacing_pkg::EXT_LSB + i_req.area];
			if (rem != 2'h0)
			begin
				next_state = bus_spacing_pkg::S_GAP;
				next_cnt   = rem - 2'h1;
			end
			else if (next_cur_ext)
			begin
				next_state = bus_spacing_pkg::S_LEAD;
			end
			else
			begin
				next_state = bus_spacing_pkg::S_STROBE;
				next_cnt   = bus_spacing_pkg::STROBE_CNT;
			end
		end
		next_sel_n = 4'hF;
		if (next_state == bus_spacing_pkg::S_LEAD || next_state == bus_spacing_pkg::S_STROBE
			|| next_state == bus_spacing_pkg::S_TRAIL)
		begin
			next_sel_n[next_cur.area] = 1'b0;
		end
		next_rd_n = !(next_state == bus_spacing_pkg::S_STROBE && !next_cur.write);
		next_wr_n = !(next_state == bus_spacing_pkg::S_STROBE && next_cur.write);
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state            <= bus_spacing_pkg::S_IDLE;
			cnt              <= 2'h0;
			since            <= 2'h3;
			cur              <= '0;
			cur_ext          <= 1'b0;
			prev             <= '0;
			prev_valid       <= 1'b0;
			o_ack            <= 1'b0;
			o_area_select_n  <= 4'hF;
			o_read_strobe_n  <= 1'b1;
			o_write_strobe_n <= 1'b1;
		end
		else
		begin
			state            <= next_state;
			cnt              <= next_cnt;
			since            <= next_since;
			cur              <= next_cur;
			cur_ext          <= next_cur_ext;
			prev             <= next_prev;
			prev_valid       <= next_prev_valid;
			o_ack            <= next_ack;
			o_area_select_n  <= next_sel_n;
			o_read_strobe_n  <= next_rd_n;
			o_write_strobe_n <= next_wr_n;
		end
	end

	property p_gap_quiet;
		@(posedge i_clk) disable iff (!rst_n)
		state == bus_spacing_pkg::S_GAP |-> o_area_select_n == 4'hF && o_read_strobe_n && o_write_strobe_n;
	endproperty
	a_gap_quiet: assert property (p_gap_quiet) else $error("select or strobe active in idle gap");

	property p_gap_ends;
		@(posedge i_clk) disable iff (!rst_n)
		state == bus_spacing_pkg::S_GAP && cnt == 2'h0 |=> state != bus_spacing_pkg::S_GAP;
	endproperty
	a_gap_ends: assert property (p_gap_ends) else $error("idle gap overran its count");

	property p_lead_select_only;
		@(posedge i_clk) disable iff (!rst_n)
		state == bus_spacing_pkg::S_LEAD |-> !o_area_select_n[cur.area] && o_read_strobe_n && o_write_strobe_n
			##2 state == bus_spacing_pkg::S_STROBE ##1 state == bus_spacing_pkg::S_TRAIL
			&& !o_area_select_n[cur.area] && o_write_strobe_n;
	endproperty
	a_lead_select_only: assert property (p_lead_select_only) else $error("stretch cycles wrong");

	property p_strobe_inside;
		@(posedge i_clk) disable iff (!rst_n)
		!o_read_strobe_n || !o_write_strobe_n |-> !o_area_select_n[cur.area];
	endproperty
	a_strobe_inside: assert property (p_strobe_inside) else $error("strobe outside select");

	property p_no_stretch;
		@(posedge i_clk) disable iff (!rst_n)
		state == bus_spacing_pkg::S_STROBE && cnt == 2'h0 && !cur_ext |=> state != bus_spacing_pkg::S_TRAIL;
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("stretch with bit clear");

	property p_ext_stable;
		@(posedge i_clk) disable iff (!rst_n)
		(state == bus_spacing_pkg::S_STROBE || state == bus_spacing_pkg::S_TRAIL) && !$past(take)
			|-> $stable(cur_ext) && $stable(cur);
	endproperty
	a_ext_stable: assert property (p_ext_stable) else $error("settings changed mid cycle");

	property p_reset_ones;
		@(posedge i_clk)
		$rose(rst_n) |-> bus_spacing_control == bus_spacing_pkg::CTRL_RESET;
	endproperty
	a_reset_ones: assert property (p_reset_ones) else $error("control not all ones after reset");

	property p_diff_area_gap;
		@(posedge i_clk) disable iff (!rst_n)
		take && at_end && !cur.write && cur.area != i_req.area
			&& idle_of(bus_spacing_control, cur.area) == 2'h3
			|=> state == bus_spacing_pkg::S_GAP && cnt == 2'h2;
	endproperty
	a_diff_area_gap: assert property (p_diff_area_gap) else $error("turnaround count wrong");

	property p_same_area_gap;
		@(posedge i_clk) disable iff (!rst_n)
		take && at_end && !cur.write && !i_req.write && cur.area == i_req.area
			&& bus_spacing_control[bus_spacing_pkg::GAP_LSB + cur.area]
			|=> state == bus_spacing_pkg::S_GAP && o_area_select_n == 4'hF;
	endproperty
	a_same_area_gap: assert property (p_same_area_gap) else $error("no select break between same-area cycles");

	property p_rd_wr_max;
		@(posedge i_clk) disable iff (!rst_n)
		take && at_end && !cur.write && i_req.write && cur.area == i_req.area
			&& idle_of(bus_spacing_control, cur.area) == 2'h0
			&& bus_spacing_control[bus_spacing_pkg::GAP_LSB + cur.area]
			|=> state == bus_spacing_pkg::S_GAP && cnt == 2'h0;
	endproperty
	a_rd_wr_max: assert property (p_rd_wr_max) else $error("write after read gap not the larger count");
endmodule

/* test/area_device_model.sv */
// Purpose: far-side device model counting strobe cycles
// Assumes: selects and strobes active low
// Notes:   counts strobes outside a single select as faults
module area_device_model
(
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic [3:0]  i_area_select_n,
	input  wire logic        i_read_strobe_n,
	input  wire logic        i_write_strobe_n,
	output      logic [15:0] o_strobe_cycles,
	output      logic [15:0] o_faults
);
	timeunit 1ns;
	timeprecision 1ps;
	logic strobe;
	assign strobe = !(i_read_strobe_n && i_write_strobe_n);
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_strobe_cycles <= 16'h0000;
			o_faults        <= 16'h0000;
		end
		else
		begin
			if (strobe)
				o_strobe_cycles <= o_strobe_cycles + 16'h0001;
			if ((strobe && &i_area_select_n) || (!i_read_strobe_n && !i_write_strobe_n)
				|| $countones(~i_area_select_n) > 1)
				o_faults <= o_faults + 16'h0001;
		end
	end
endmodule

/* test/test_bus_cycle_spacing_control.sv */
// Purpose: self-checking bench for the bus cycle spacing control
// Assumes: requests held until ack and select, next one presented at the select edge
// Notes:   counts all-off cycles between bus cycles against a model
module test_bus_cycle_spacing_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     i_clk        = 1'b0;
	logic                     i_arst_n     = 1'b0;
	logic [3:0]               i_address    = 4'h0;
	logic                     i_read       = 1'b0;
	logic                     i_write      = 1'b0;
	logic [31:0]              i_writedata  = 32'h0;
	logic [3:0]               i_byteenable = 4'hF;
	logic                     i_req_valid  = 1'b0;
	bus_spacing_pkg::access_s i_req        = '0;
	logic [31:0]              o_readdata;
	logic                     o_waitrequest;
	logic                     o_ack;
	logic [3:0]               o_area_select_n;
	logic                     o_read_strobe_n;
	logic                     o_write_strobe_n;
	logic [15:0]              strobe_cycles;
	logic [15:0]              dev_faults;
	logic [31:0]              q;
	logic [15:0]              ctrl;
	int                       fails = 0;
	int                       total_checks = 0;
	int                       pa, pw, nacc;
	bus_cycle_spacing_control u_bus_cycle_spacing_control
	(
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_req_valid(i_req_valid),
		.i_req(i_req), .o_ack(o_ack), .o_area_select_n(o_area_select_n),
		.o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n)
	);
	area_device_model u_area_device_model
	(
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_area_select_n(o_area_select_n),
		.i_read_strobe_n(o_read_strobe_n), .i_write_strobe_n(o_write_strobe_n),
		.o_strobe_cycles(strobe_cycles), .o_faults(dev_faults)
	);
	initial
	begin
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic reset_dut;
		i_arst_n <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_arst_n <= 1'b1;
		ctrl = 16'hFFFF;
		nacc = 0;
		repeat (4) @(posedge i_clk);
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] r);
		int k;
		@(posedge i_clk);
		i_address <= a;
		i_write <= wr;
		i_read <= !wr;
		i_writedata <= d;
		i_byteenable <= be;
		k = 0;
		do
		begin
			@(posedge i_clk);
			k++;
		end
		while (o_waitrequest !== 1'b0 && k < 50);
		if (k >= 50)
			fails++;
		r = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask
	task automatic set_ctrl(input logic [15:0] d, input logic [3:0] be);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}};
		bus(1'b1, bus_spacing_pkg::ADDR_CTRL, {16'hA5A5, d}, be, q);
		ctrl = (ctrl & ~m) | (d & m);
		bus(1'b0, bus_spacing_pkg::ADDR_CTRL, 32'h0, 4'hF, q);
		check(q, {16'h0000, ctrl});
	endtask
	function automatic int exp_gap(int a, int w);
		int iw, cw;
		iw = int'(ctrl[8 + 2 * pa +: 2]);
		cw = (pa == a) ? int'(ctrl[4 + a]) : 0;
		if (pw == 0 && (pa != a || w != 0))
			return (iw > cw) ? iw : cw;
		return cw;
	endfunction
	task automatic access(input int a, input int w, input int meas);
		int k, cnt, seen;
		logic [1:0] st;
		i_req_valid <= 1'b1;
		i_req <= '{area: 2'(a), write: w[0]};
		k = 0;
		cnt = 0;
		seen = 0;
		do
		begin
			@(posedge i_clk);
			k++;
			if (o_ack === 1'b1)
				seen = 1;
			if (o_area_select_n === 4'hF && o_read_strobe_n === 1'b1 && o_write_strobe_n === 1'b1)
				cnt++;
		end
		while (!(seen == 1 && o_area_select_n[a] === 1'b0) && k < 60);
		if (k >= 60)
			fails++;
		if (meas != 0)
			check(32'(cnt), 32'(exp_gap(a, w)));
		st = ctrl[a] ? 2'b11 : (w != 0 ? 2'b10 : 2'b01);
		check({30'h0, o_read_strobe_n, o_write_strobe_n}, {30'h0, st});
		pa = a;
		pw = w;
		nacc++;
	endtask
	task automatic burst(input int n);
		for (int i = 0; i < n; i++)
			access($urandom_range(3), $urandom_range(1), i);
		i_req_valid <= 1'b0;
		repeat (12) @(posedge i_clk);
		bus(1'b0, bus_spacing_pkg::ADDR_STAT, 32'h0, 4'hF, q);
		check(q, {27'h0, 1'b1, pw[0], 2'(pa), 1'b0});
		check({16'h0, strobe_cycles}, 32'(2 * nacc));
		check({16'h0, dev_faults}, 32'h0);
	endtask
	initial
	begin
		repeat (20000) @(posedge i_clk);
		fails++;
		stop_test();
	end
	initial
	begin
		void'($urandom(39));
		reset_dut();
		bus(1'b0, bus_spacing_pkg::ADDR_CTRL, 32'h0, 4'hF, q);
		check(q, {16'h0000, bus_spacing_pkg::CTRL_RESET});
		burst(8);
		bus(1'b1, 4'hC, 32'hFFFF0000, 4'hF, q);
		bus(1'b0, 4'hC, 32'h0, 4'hF, q);
		check(q, 32'h0);
		set_ctrl(16'h0000, 4'h3);
		burst(8);
		repeat (6)
		begin
			set_ctrl(16'($urandom), 4'($urandom));
			burst(10);
		end
		set_ctrl(16'h1234, 4'h3);
		reset_dut();
		bus(1'b0, bus_spacing_pkg::ADDR_CTRL, 32'h0, 4'hF, q);
		check(q, 32'h0000FFFF);
		stop_test();
	end
endmodule
